// File: bssm_pkg.sv
// Overview of operation
// - JTAG and parallel slave ports are host-driven; all other primaries are read by us.
// - Mode 1000 selects octal flash, x8, secure, fallback, 8 Gb search limit.
// - Every SD/eMMC primary mode searches up to 8191 FAT files.
// - After any reset the boot mode is read before any image fetch.
// - After firmware load the management processor is released to run.
// - Secondary device used only if meta header names one; else primary.
// - On load error, except in the slave modes, increment image select by 1, then request system reset.
// - In JTAG mode errors never cause a system reset.
// - A run-time command writes a new image select value.
// - Flash search starts at select times 32k and steps by 32k.
// - Search address wraps to zero past device size until limit covered.
// - Dual-stacked flash: only lower device during boot, upper after.
// - Select zero names boot.bin; else boot plus four decimal digits.
// - Highest file number searched is 8190.
// - An image found on SD/eMMC writes its location into image select.
// - Image select holds raw-or-file flag plus file number or offset.
// - Firmware continues from the location held in image select.
// - USB secondary images land at fixed address 5000000 hex.
// - PCIe endpoint is accepted only as a secondary source.
// - Firmware keeps running until an error halts it, or until the next power-on or system reset.
// shared constants and types of the boot source sequencer
// assumes byte addressing on flash and file numbering on cards
package bssm_pkg;
  localparam int ADDR_W = 36;
  localparam int FILE_W = 13;
  localparam int SEL_W = 32;
  localparam int STEP_SH = 15;
  localparam logic [3:0] MODE_JTAG = 4'h0;
  localparam logic [3:0] MODE_QSPI24 = 4'h1;
  localparam logic [3:0] MODE_QSPI32 = 4'h2;
  localparam logic [3:0] MODE_SD0 = 4'h3;
  localparam logic [3:0] MODE_SD1 = 4'h5;
  localparam logic [3:0] MODE_EMMC1 = 4'h6;
  localparam logic [3:0] MODE_OSPI = 4'h8;
  localparam logic [3:0] MODE_SMAP = 4'ha;
  localparam logic [3:0] MODE_SD1V3 = 4'he;
  localparam logic [5:0] W_X1 = 6'h01;
  localparam logic [5:0] W_X124 = 6'h07;
  localparam logic [5:0] W_X148 = 6'h0d;
  localparam logic [5:0] W_X4 = 6'h04;
  localparam logic [5:0] W_X8 = 6'h08;
  localparam logic [5:0] W_X8_32 = 6'h38;
  localparam logic [ADDR_W-1:0] STEP_32K = 36'h0_0000_8000;
  localparam logic [ADDR_W-1:0] LIM_128MB = 36'h0_0100_0000;
  localparam logic [ADDR_W-1:0] LIM_256MB = 36'h0_0200_0000;
  localparam logic [ADDR_W-1:0] LIM_4GB = 36'h0_2000_0000;
  localparam logic [ADDR_W-1:0] LIM_8GB = 36'h0_4000_0000;
  localparam logic [FILE_W-1:0] FILE_MAX = 13'h1ffe;
  localparam logic [FILE_W-1:0] FILE_LIMIT = 13'h1fff;
  localparam logic [31:0] USB_DEST = 32'h0500_0000;
  typedef enum logic [3:0] {
    DEV_NONE, DEV_JTAG, DEV_QSPI24, DEV_QSPI32, DEV_SD0, DEV_SD1, DEV_EMMC1,
    DEV_OSPI, DEV_SMAP, DEV_PCIE, DEV_USB, DEV_ETH
  } bssm_dev_t;
  typedef enum logic [2:0] {
    ST_MODE, ST_SEARCH, ST_LOAD, ST_RUN, ST_FAIL, ST_HALT
  } bssm_state_t;
  typedef struct packed {
    bssm_dev_t dev;
    logic slave;
    logic file;
    logic secure;
    logic fallback;
    logic [5:0] width;
    logic [ADDR_W-1:0] lim;
  } bssm_cfg_t;
  typedef struct packed {
    logic raw;
    logic [SEL_W-1:0] val;
  } bssm_sel_t;
endpackage

// File: bssm_core.sv
// boot source decode, image search, load hand-off and fallback sequencing
// assumes the image source and loader answer with done pulses
`timescale 1ns/1ps
module bssm_core import bssm_pkg::*; #(
  parameter logic [ADDR_W-1:0] FLASH_BYTES = LIM_8GB
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic system_reset_i,
  input wire logic por_i,
  // boot mode straps
  input wire logic [3:0] boot_mode_i,
  input wire logic dual_parallel_i,
  // image search port
  output logic src_req_o,
  output logic src_file_o,
  output logic [ADDR_W-1:0] src_addr_o,
  output logic name_plain_o,
  output logic [15:0] name_bcd_o,
  input wire logic src_done_i,
  input wire logic src_found_i,
  input wire logic src_raw_i,
  input wire logic [SEL_W-1:0] src_loc_i,
  // firmware load port
  output logic ld_req_o,
  input wire logic ld_done_i,
  input wire logic ld_err_i,
  // running firmware
  output logic mgmt_run_o,
  output logic flash_upper_o,
  input wire logic meta_valid_i,
  input wire bssm_dev_t meta_sec_i,
  input wire logic fw_err_i,
  input wire logic cmd_valid_i,
  input wire logic [SEL_W-1:0] cmd_val_i,
  // status
  output bssm_cfg_t cfg_o,
  output bssm_sel_t img_sel_o,
  output logic sec_act_o,
  output bssm_dev_t sec_dev_o,
  output logic [31:0] sec_dest_o,
  output logic sysrst_req_o,
  output logic boot_fail_o,
  output logic halted_o
);
  typedef struct packed {
    bssm_state_t st;
    bssm_cfg_t cfg;
    bssm_sel_t sel;
    logic by_file;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] cov;
    logic [FILE_W-1:0] fnum;
    logic src_req;
    logic ld_req;
    logic run;
    logic sec_act;
    bssm_dev_t sec_dev;
    logic rst_req;
    logic fail;
    logic halt;
  } bssm_regs_t;

  localparam bssm_regs_t REG_RST = '0;

  bssm_regs_t s;
  bssm_regs_t next_s;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (system_reset_i || por_i);

  function automatic bssm_cfg_t decode(input logic [3:0] m, input logic dp);
    bssm_cfg_t c;
    c = '0;
    c.secure = 1'b1;
    c.fallback = 1'b1;
    case (m)
      MODE_JTAG: begin
        c.dev = DEV_JTAG;
        c.slave = 1'b1;
        c.secure = 1'b0;
        c.fallback = 1'b0;
        c.width = W_X1;
      end
      MODE_SMAP: begin
        c.dev = DEV_SMAP;
        c.slave = 1'b1;
        c.fallback = 1'b0;
        c.width = W_X8_32;
      end
      MODE_QSPI24: begin
        c.dev = DEV_QSPI24;
        c.width = dp ? W_X8 : W_X124;
        c.lim = dp ? LIM_256MB : LIM_128MB;
      end
      MODE_QSPI32: begin
        c.dev = DEV_QSPI32;
        c.width = dp ? W_X8 : W_X124;
        c.lim = dp ? LIM_8GB : LIM_4GB;
      end
      MODE_OSPI: begin
        c.dev = DEV_OSPI;
        c.width = W_X8;
        c.lim = LIM_8GB;
      end
      // card modes search by file count
      MODE_SD0, MODE_SD1, MODE_SD1V3: begin
        c.dev = (m == MODE_SD0) ? DEV_SD0 : DEV_SD1;
        c.file = 1'b1;
        c.width = W_X4;
      end
      MODE_EMMC1: begin
        c.dev = DEV_EMMC1;
        c.file = 1'b1;
        c.width = W_X148;
      end
      // no primary code maps to the endpoint role
      default: begin
        c.dev = DEV_NONE;
      end
    endcase
    return c;
  endfunction

  // four decimal digits for the numbered file name
  function automatic logic [15:0] to_bcd(input logic [FILE_W-1:0] v);
    logic [15:0] b;
    b = '0;
    for (int i = FILE_W - 1; i >= 0; i--) begin
      for (int d = 0; d < 4; d++) begin
        if (b[d*4 +: 4] > 4'h4) begin
          b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
        end
      end
      b = {b[14:0], v[i]};
    end
    return b;
  endfunction

  logic err;
  logic [ADDR_W-1:0] start;
  logic [ADDR_W-1:0] step_addr;
  logic [ADDR_W-1:0] step_cov;

  always_comb begin
    next_s = s;
    next_s.rst_req = 1'b0;
    err = 1'b0;
    // search start is select times 32k
    start = ADDR_W'(s.sel.val) << STEP_SH;
    step_addr = s.addr + STEP_32K;
    step_cov = s.cov + STEP_32K;
    case (s.st)
      // mode read first after any reset
      ST_MODE: begin
        next_s.cfg = decode(boot_mode_i, dual_parallel_i);
        next_s.cov = '0;
        if (next_s.cfg.dev == DEV_NONE) begin
          next_s.fail = 1'b1;
          next_s.st = ST_FAIL;
        end else if (next_s.cfg.slave) begin
          // slave modes: host pushes image, no search
          next_s.ld_req = 1'b1;
          next_s.st = ST_LOAD;
        end else if (next_s.cfg.file && !s.sel.raw) begin
          next_s.by_file = 1'b1;
          next_s.fnum = s.sel.val[FILE_W-1:0];
          // numbers above the top file are out of range
          if (s.sel.val > SEL_W'(FILE_MAX)) begin
            next_s.fail = 1'b1;
            next_s.st = ST_FAIL;
          end else begin
            next_s.src_req = 1'b1;
            next_s.st = ST_SEARCH;
          end
        end else begin
          // raw card search resumes from held offset
          next_s.by_file = 1'b0;
          next_s.addr = next_s.cfg.file ? ADDR_W'(s.sel.val) : start;
          // start beyond a small device wraps to zero
          if (next_s.addr >= FLASH_BYTES) begin
            next_s.addr = '0;
          end
          next_s.src_req = 1'b1;
          next_s.st = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (src_done_i && src_found_i) begin
          // found card image records its location
          if (s.cfg.file) begin
            // raw flag with file number or offset
            next_s.sel.raw = src_raw_i;
            next_s.sel.val = src_loc_i;
          end
          next_s.src_req = 1'b0;
          next_s.ld_req = 1'b1;
          next_s.st = ST_LOAD;
        end else if (src_done_i && s.by_file) begin
          // stop after the last numbered file
          if (s.fnum >= FILE_MAX) begin
            next_s.src_req = 1'b0;
            next_s.fail = 1'b1;
            next_s.st = ST_FAIL;
          end else begin
            next_s.fnum = s.fnum + 1'b1;
          end
        end else if (src_done_i) begin
          next_s.cov = step_cov;
          // limit covered with no header found
          if (step_cov >= s.cfg.lim) begin
            next_s.src_req = 1'b0;
            next_s.fail = 1'b1;
            next_s.st = ST_FAIL;
          end else if (step_addr >= FLASH_BYTES) begin
            next_s.addr = '0;
          end else begin
            next_s.addr = step_addr;
          end
        end
      end
      ST_LOAD: begin
        if (ld_done_i) begin
          next_s.ld_req = 1'b0;
          if (ld_err_i) begin
            err = 1'b1;
          end else begin
            next_s.run = 1'b1;
            next_s.st = ST_RUN;
          end
        end
      end
      // stays here until an error or the next reset
      ST_RUN: begin
        if (cmd_valid_i) begin
          next_s.sel.val = cmd_val_i;
        end
        // secondary only when the header names one
        if (meta_valid_i && meta_sec_i != DEV_NONE) begin
          if (meta_sec_i == s.cfg.dev || meta_sec_i == DEV_JTAG) begin
            err = 1'b1;
          end else begin
            next_s.sec_act = 1'b1;
            next_s.sec_dev = meta_sec_i;
          end
        end
        if (fw_err_i) begin
          err = 1'b1;
        end
      end
      ST_FAIL: begin
        next_s.fail = 1'b1;
      end
      ST_HALT: begin
        next_s.halt = 1'b1;
      end
      default: begin
        next_s.st = ST_FAIL;
      end
    endcase
    if (err) begin
      next_s.halt = 1'b1;
      next_s.st = ST_HALT;
      // jtag keeps the system up for debug
      if (s.cfg.dev != DEV_JTAG && s.cfg.fallback) begin
        // next image then system reset; error beats command
        next_s.sel.val = s.sel.val + 1'b1;
        next_s.rst_req = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      s <= REG_RST;
    end else if (system_reset_i) begin
      // image select survives the fallback reset
      s <= REG_RST;
      s.sel <= s.sel;
    end else begin
      s <= next_s;
    end
  end

  assign src_req_o = s.src_req;
  assign src_file_o = s.by_file;
  assign src_addr_o = s.by_file ? ADDR_W'(s.fnum) : s.addr;
  assign name_plain_o = (s.fnum == '0);
  assign name_bcd_o = to_bcd(s.fnum);
  assign ld_req_o = s.ld_req;
  assign mgmt_run_o = s.run;
  // upper stacked device only once firmware runs
  assign flash_upper_o = s.run;
  assign cfg_o = s.cfg;
  assign img_sel_o = s.sel;
  assign sec_act_o = s.sec_act;
  assign sec_dev_o = s.sec_dev;
  // fixed landing address for usb images
  assign sec_dest_o = (s.sec_act && s.sec_dev == DEV_USB) ? USB_DEST : '0;
  assign sysrst_req_o = s.rst_req;
  assign boot_fail_o = s.fail;
  assign halted_o = s.halt;

  sequence seq_load_ok;
    ld_req_o && ld_done_i && !ld_err_i;
  endsequence
  sequence seq_fw_err;
    s.st == ST_RUN && fw_err_i && !meta_valid_i;
  endsequence

  a_slave_no_search: assert property (
    s.st == ST_MODE && (boot_mode_i == MODE_JTAG || boot_mode_i == MODE_SMAP)
    |=> ld_req_o && !src_req_o)
    else $error("slave mode started a search");
  a_ospi_decode: assert property (
    s.st == ST_MODE && boot_mode_i == MODE_OSPI
    |=> cfg_o.dev == DEV_OSPI && cfg_o.lim == LIM_8GB && cfg_o.width == W_X8)
    else $error("octal mode decoded wrong");
  a_file_top: assert property (
    src_req_o && src_file_o |-> src_addr_o <= ADDR_W'(FILE_MAX))
    else $error("file number past top");
  a_run_after_load: assert property (
    seq_load_ok |=> mgmt_run_o ##1 mgmt_run_o)
    else $error("processor not released");
  a_err_increment: assert property (
    seq_fw_err ##0 (cfg_o.dev != DEV_JTAG && cfg_o.fallback)
    |=> sysrst_req_o && img_sel_o.val == $past(img_sel_o.val) + 1'b1)
    else $error("fallback step missing");
  a_jtag_no_reset: assert property (
    seq_fw_err ##0 cfg_o.dev == DEV_JTAG |=> !sysrst_req_o && halted_o [*2])
    else $error("jtag error reset");
  a_wrap_bound: assert property (
    src_req_o && !src_file_o |-> src_addr_o < FLASH_BYTES)
    else $error("search address beyond device");
  a_found_record: assert property (
    s.st == ST_SEARCH && src_done_i && src_found_i && cfg_o.file
    |=> img_sel_o.val == $past(src_loc_i) && img_sel_o.raw == $past(src_raw_i))
    else $error("card location not recorded");
  a_usb_dest: assert property (
    sec_act_o && sec_dev_o == DEV_USB |-> sec_dest_o == USB_DEST)
    else $error("usb landing address wrong");
  a_no_pcie_primary: assert property (
    cfg_o.dev != DEV_PCIE)
    else $error("endpoint used as primary");
endmodule

// File: bssm_src_model.sv
// behavioural image source and firmware loader facing the sequencer
// assumes the sequencer holds its requests as levels until answered
`timescale 1ns/1ps
module bssm_src_model import bssm_pkg::*; (
  // clock
  input wire logic clk_i,
  // search port
  input wire logic src_req_i,
  input wire logic [ADDR_W-1:0] src_addr_i,
  input wire logic [ADDR_W-1:0] hit_addr_i,
  output logic src_done_o,
  output logic src_found_o,
  output logic src_raw_o,
  output logic [SEL_W-1:0] src_loc_o,
  // load port
  input wire logic ld_req_i,
  input wire logic ld_fail_i,
  output logic ld_done_o,
  output logic ld_err_o
);
  logic hit;
  assign hit = src_req_i && !src_done_o && src_addr_i == hit_addr_i;
  initial begin
    src_done_o = 1'b0;
    src_found_o = 1'b0;
    src_raw_o = 1'b1;
    src_loc_o = 32'hffff_ffff;
    ld_done_o = 1'b0;
    ld_err_o = 1'b0;
  end
  // files on fat volume
  // a probe every other cycle; idle location shows a changing pattern
  always @(negedge clk_i) begin
    src_done_o <= src_req_i && !src_done_o;
    src_found_o <= hit;
    src_raw_o <= !hit;
    src_loc_o <= hit ? src_addr_i[SEL_W-1:0] : ~src_loc_o;
    ld_done_o <= ld_req_i && !ld_done_o;
    ld_err_o <= ld_req_i && !ld_done_o && ld_fail_i;
  end
endmodule

// File: testbench.sv
// self-checking bench for the boot source sequencer
// assumes the behavioural source model answers every search and load
`timescale 1ns/1ps
module testbench;
  import bssm_pkg::*;
  logic clk_i, system_reset_i, por_i, dual_parallel_i;
  logic [3:0] boot_mode_i;
  logic src_req_o, src_file_o, name_plain_o, src_done_i, src_found_i, src_raw_i;
  logic [ADDR_W-1:0] src_addr_o, hit_addr;
  logic [15:0] name_bcd_o;
  logic [SEL_W-1:0] src_loc_i, cmd_val_i;
  logic ld_req_o, ld_done_i, ld_err_i, mgmt_run_o, flash_upper_o, meta_valid_i;
  logic fw_err_i, cmd_valid_i, sec_act_o, sysrst_req_o, boot_fail_o, halted_o;
  bssm_dev_t meta_sec_i, sec_dev_o;
  bssm_cfg_t cfg_o;
  bssm_sel_t img_sel_o;
  logic [31:0] sec_dest_o;
  logic ld_fail;
  int n_fail = 0;
  int num_checks = 0;
  // small flash so the wrap shows within a few probes
  bssm_core #(.FLASH_BYTES(36'h0_0002_0000)) u_dut (
    .clk_i(clk_i), .system_reset_i(system_reset_i), .por_i(por_i), .boot_mode_i(boot_mode_i),
    .dual_parallel_i(dual_parallel_i), .src_req_o(src_req_o), .src_file_o(src_file_o),
    .src_addr_o(src_addr_o), .name_plain_o(name_plain_o), .name_bcd_o(name_bcd_o),
    .src_done_i(src_done_i), .src_found_i(src_found_i), .src_raw_i(src_raw_i),
    .src_loc_i(src_loc_i), .ld_req_o(ld_req_o), .ld_done_i(ld_done_i), .ld_err_i(ld_err_i),
    .mgmt_run_o(mgmt_run_o), .flash_upper_o(flash_upper_o), .meta_valid_i(meta_valid_i),
    .meta_sec_i(meta_sec_i), .fw_err_i(fw_err_i), .cmd_valid_i(cmd_valid_i),
    .cmd_val_i(cmd_val_i), .cfg_o(cfg_o), .img_sel_o(img_sel_o), .sec_act_o(sec_act_o),
    .sec_dev_o(sec_dev_o), .sec_dest_o(sec_dest_o), .sysrst_req_o(sysrst_req_o),
    .boot_fail_o(boot_fail_o), .halted_o(halted_o));
  bssm_src_model u_src (.clk_i(clk_i), .src_req_i(src_req_o), .src_addr_i(src_addr_o),
    .hit_addr_i(hit_addr), .src_done_o(src_done_i), .src_found_o(src_found_i),
    .src_raw_o(src_raw_i), .src_loc_o(src_loc_i), .ld_req_i(ld_req_o),
    .ld_fail_i(ld_fail), .ld_done_o(ld_done_i), .ld_err_o(ld_err_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic boot(input logic p, input logic [3:0] m, input logic [ADDR_W-1:0] h);
    @(negedge clk_i);
    por_i = p;
    system_reset_i = !p;
    boot_mode_i = m;
    hit_addr = h;
    repeat (12) @(negedge clk_i);
    por_i = 1'b0;
    system_reset_i = 1'b0;
  endtask
  task automatic probes(input logic [ADDR_W-1:0] a0, input logic [ADDR_W-1:0] a1);
    int i;
    for (i = 0; i < 20 && src_req_o !== 1'b1; i++) @(negedge clk_i);
    chk(src_addr_o, a0);
    chk(flash_upper_o, 1'b0);
    for (i = 0; i < 20 && src_addr_o === a0; i++) @(negedge clk_i);
    chk(src_addr_o, a1);
  endtask
  task automatic wait_run;
    int i;
    for (i = 0; i < 40 && mgmt_run_o !== 1'b1; i++) @(negedge clk_i);
    chk(mgmt_run_o, 1'b1);
    chk(ld_req_o, 1'b0);
  endtask
  task automatic cmd(input logic [SEL_W-1:0] v);
    cmd_val_i = v;
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    chk(img_sel_o.val, v);
  endtask
  task automatic meta(input bssm_dev_t d);
    meta_sec_i = d;
    meta_valid_i = 1'b1;
    @(negedge clk_i);
    meta_valid_i = 1'b0;
  endtask
  task automatic fault(input logic m, input logic r, input logic [SEL_W-1:0] v);
    if (m) meta(DEV_OSPI);
    else begin
      fw_err_i = 1'b1;
      @(negedge clk_i);
      fw_err_i = 1'b0;
    end
    chk(halted_o, 1'b1);
    chk(sysrst_req_o, r);
    chk(img_sel_o.val, v);
    @(negedge clk_i);
    chk(sysrst_req_o, 1'b0);
  endtask
  task automatic t_flash;
    boot(1'b1, MODE_OSPI, STEP_32K);
    probes(36'h0, STEP_32K);
    chk(cfg_o.dev, DEV_OSPI);
    chk(cfg_o.width, W_X8);
    chk(cfg_o.lim, LIM_8GB);
    chk({cfg_o.slave, cfg_o.secure, cfg_o.fallback}, 3'b011);
    chk(src_file_o, 1'b0);
    wait_run();
    chk(flash_upper_o, 1'b1);
    cmd(32'h0000_0002);
    fault(1'b0, 1'b1, 32'h0000_0003);
  endtask
  task automatic t_wrap;
    boot(1'b0, MODE_OSPI, 36'h0);
    chk(img_sel_o.val, 32'h0000_0003);
    probes(36'h0_0001_8000, 36'h0);
    wait_run();
    meta(DEV_NONE);
    chk(sec_act_o, 1'b0);
    meta(DEV_USB);
    chk(sec_act_o, 1'b1);
    chk(sec_dev_o, DEV_USB);
    chk(sec_dest_o, USB_DEST);
    fault(1'b1, 1'b1, 32'h0000_0004);
  endtask
  task automatic t_jtag;
    boot(1'b1, MODE_JTAG, 36'h0);
    wait_run();
    chk(cfg_o.slave, 1'b1);
    fault(1'b0, 1'b0, 32'h0000_0000);
  endtask
  task automatic t_modes;
    int i;
    dual_parallel_i = 1'b1;
    boot(1'b1, MODE_QSPI24, 36'h0);
    wait_run();
    chk(cfg_o.lim, LIM_256MB);
    chk(cfg_o.width, W_X8);
    ld_fail = 1'b1;
    boot(1'b1, MODE_QSPI32, 36'h0);
    for (i = 0; i < 20 && halted_o !== 1'b1; i++) @(negedge clk_i);
    chk(cfg_o.lim, LIM_8GB);
    chk({halted_o, sysrst_req_o, mgmt_run_o}, 3'b110);
    chk(img_sel_o.val, 32'h0000_0001);
    ld_fail = 1'b0;
    dual_parallel_i = 1'b0;
    boot(1'b1, MODE_SMAP, 36'h0);
    wait_run();
    chk({cfg_o.slave, cfg_o.fallback, src_req_o}, 3'b100);
    fault(1'b0, 1'b0, 32'h0000_0000);
    boot(1'b1, 4'h4, 36'h1);
    @(negedge clk_i);
    chk({boot_fail_o, src_req_o, ld_req_o}, 3'b100);
    // no address ever hits: the whole limit is probed, wrapping the small flash
    boot(1'b1, MODE_QSPI24, 36'h1);
    for (i = 0; i < 1200 && boot_fail_o !== 1'b1; i++) @(negedge clk_i);
    chk(cfg_o.width, W_X124);
    chk(i, 2 * (LIM_128MB >> STEP_SH));
    chk({boot_fail_o, mgmt_run_o}, 2'b10);
  endtask
  task automatic t_card;
    int i;
    boot(1'b1, MODE_SD0, 36'h1);
    @(negedge clk_i);
    chk({src_file_o, name_plain_o}, 2'b11);
    probes(36'h0, 36'h1);
    chk({name_plain_o, name_bcd_o}, 17'h0_0001);
    wait_run();
    chk(img_sel_o, 33'h0_0000_0001);
    cmd(32'h0000_1ffe);
    fault(1'b0, 1'b1, 32'h0000_1fff);
    boot(1'b0, MODE_SD0, 36'h1);
    for (i = 0; i < 20 && boot_fail_o !== 1'b1; i++) @(negedge clk_i);
    chk({boot_fail_o, mgmt_run_o}, 2'b10);
  endtask
  initial begin
    por_i = 1'b1;
    system_reset_i = 1'b0;
    dual_parallel_i = 1'b0;
    boot_mode_i = MODE_OSPI;
    hit_addr = 36'h0;
    meta_valid_i = 1'b0;
    meta_sec_i = DEV_NONE;
    fw_err_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_val_i = 32'h0000_0000;
    ld_fail = 1'b0;
    t_flash();
    t_wrap();
    t_jtag();
    t_modes();
    t_card();
    finish_test();
  end
  // whole run is somewhat over a thousand cycles
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end
endmodule
